// ---- design/lgas_map.svh ----
`ifndef LGAS_MAP_SVH
`define LGAS_MAP_SVH

// Instruction codes
`define LGAS_INS_CPL        8'h02
`define LGAS_INS_NX         8'h03
`define LGAS_INS_CLINE      8'h04
`define LGAS_INS_DS_LO      8'h08
`define LGAS_INS_DS_HI      8'h09
`define LGAS_INS_CUR_LO     8'h0a
`define LGAS_INS_CUR_HI     8'h0b

// Field positions
`define LGAS_STAT_BUSY_BIT  7
`define LGAS_CPL_MSB        6
`define LGAS_NX_MSB         6
`define LGAS_CLINE_MSB      3
`define LGAS_CHAR_HI_MSB    3

// Reset values (count fields hold value minus one; addresses do not)
`define LGAS_CPL_RST        7'h01
`define LGAS_NX_RST         7'h00
`define LGAS_CLINE_RST      4'h7
`define LGAS_DS_RST         8'h00
`define LGAS_CUR_RST        16'h0000

// Timing
`define LGAS_CLK_PERIOD_NS  8
`define LGAS_EXEC_TIME_NS   4000
`define LGAS_EXEC_CYC       (`LGAS_EXEC_TIME_NS / `LGAS_CLK_PERIOD_NS)

// Host controller register map (AXI4-Lite)
`define LGAS_HOST_CMD_OFS   4'h0
`define LGAS_HOST_STAT_OFS  4'h4
`define LGAS_BUSY_IDLE_BIT  31

`endif

// ---- design/lgas_pkg.sv ----
package lgas_pkg;

    typedef logic [7:0]  lgas_byte_t;
    typedef logic [8:0]  lgas_cnt_t;
    typedef logic [15:0] lgas_addr_t;

    typedef enum logic [2:0] {
        HST_IDLE,
        HST_POLL,
        HST_STAT,
        HST_CODE,
        HST_PARAM
    } lgas_hst_e;

    typedef struct packed {
        lgas_byte_t instr;
        logic       busy;
        lgas_cnt_t  cnt;
        logic [6:0] cpl;
        logic [6:0] nx;
        logic [3:0] cline;
        lgas_byte_t ds_lo;
        lgas_byte_t ds_hi;
        lgas_addr_t start;
        logic [6:0] scan;
        lgas_byte_t dots;
        lgas_byte_t dout;
        logic       oe_n;
    } lgas_dev_s;

    typedef struct packed {
        lgas_addr_t addr;
    } lgas_ctr_s;

    typedef struct packed {
        lgas_hst_e  st;
        logic       strobe;
        logic       rs;
        logic       rw;
        lgas_byte_t dout;
        logic       oe_n;
        lgas_byte_t code;
        lgas_byte_t param;
        lgas_byte_t hi_shadow;
        logic       fix_hi;
        lgas_byte_t last_stat;
        logic       awready;
        logic       wready;
        logic       bvalid;
        logic [1:0] bresp;
        logic       arready;
        logic       rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } lgas_hst_s;

endpackage

// ---- design/lgas_bus_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface lgas_bus_if;
    logic       bus_strobe;
    logic       register_select;
    logic       read_write;
    logic [7:0] host_do;
    logic       host_oe_n;
    logic [7:0] dev_do;
    logic       dev_oe_n;
    logic [7:0] host_data_bus;

    // Weak pull-up when nobody drives
    assign host_data_bus = !host_oe_n ? host_do : (!dev_oe_n ? dev_do : 8'hff);

    modport dev (
        input  bus_strobe,
        input  register_select,
        input  read_write,
        input  host_data_bus,
        output dev_do,
        output dev_oe_n
    );

    modport host (
        output bus_strobe,
        output register_select,
        output read_write,
        output host_do,
        output host_oe_n,
        input  host_data_bus
    );
endinterface

`default_nettype wire

// ---- design/lgas_cursor_ctr.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "lgas_map.svh"

module lgas_cursor_ctr (
    input  wire logic            sys_clk,
    input  wire logic            rst_n,
    input  wire logic            load_lo,
    input  wire logic            load_hi,
    input  wire logic            inc,
    input  wire logic [7:0]      load_data,
    output var  lgas_pkg::lgas_addr_t addr
);
    import lgas_pkg::*;

    lgas_ctr_s ctr_r;
    lgas_ctr_s ctr_nxt;

    always_comb begin
        ctr_nxt = ctr_r;
        if (load_hi) begin
            ctr_nxt.addr[15:8] = load_data;
        end else if (load_lo) begin
            ctr_nxt.addr[7:0] = load_data;
            // Low byte MSB falling carries into the high byte
            if (ctr_r.addr[7] && !load_data[7]) begin
                ctr_nxt.addr[15:8] = ctr_r.addr[15:8] + 8'h01;
            end
        end else if (inc) begin
            ctr_nxt.addr = ctr_r.addr + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctr_r.addr <= `LGAS_CUR_RST;
        end else begin
            ctr_r <= ctr_nxt;
        end
    end

    assign addr = ctr_r.addr;
endmodule // lgas_cursor_ctr

`default_nettype wire

// ---- design/lgas_device.sv ----
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "lgas_map.svh"

// Function
// - Code with select high, parameter executes
// - Busy while executing; new parameters ignored
// - Characters per line: even 2..128, minus one
// - Time divisions 1..128, minus one
// - Scan over programmed time divisions
// - Cursor line 1..16, minus one
// - Cursor drawn on selected cell line
// - Cursor width equals horizontal pitch
// - Cursor dots override character dots
// - Cursor hidden when beyond vertical pitch
// - Display start address feeds top-left fetch
// - Character mode uses twelve start bits
// - Start address loaded by two instructions
// - Cursor loads write low or high half
// - Cursor address addresses every RAM transfer
// - Cursor cell matches cursor address
// - Sixteen-bit up-counter, rippling carries
// - Low MSB falling increments high byte
// - Host rewrites high after low
// - High byte alone may be written
// - Each setup finishes within four microseconds
module lgas_device (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    lgas_bus_if.dev               bus,
    input  wire logic             graphic_mode,
    input  wire logic             cursor_enable,
    input  wire logic [3:0]       vertical_pitch,
    input  wire logic [2:0]       horizontal_pitch,
    input  wire logic             line_tick,
    input  wire logic [3:0]       cell_line,
    input  wire logic [15:0]      cell_addr,
    input  wire logic [7:0]       char_dots,
    input  wire logic             ram_xfer_done,
    output var  logic [6:0]       chars_per_line_count,
    output var  logic [6:0]       time_division_count,
    output var  logic [3:0]       cursor_line_value,
    output var  logic [15:0]      display_start_addr,
    output var  lgas_pkg::lgas_addr_t ram_addr,
    output var  logic [6:0]       scan_line,
    output var  logic [7:0]       pixel_dots,
    output var  logic             busy
);
    import lgas_pkg::*;

    lgas_dev_s  dev_r;
    lgas_dev_s  dev_nxt;

    logic       exec;
    logic       ld_lo;
    logic       ld_hi;
    logic [7:0] pitch_mask;
    logic       cur_show;
    lgas_addr_t cur_addr;

    // Counter kept apart so its carry rule stays local
    lgas_cursor_ctr u_cursor (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .load_lo   (ld_lo),
        .load_hi   (ld_hi),
        .inc       (ram_xfer_done),
        .load_data (bus.host_data_bus),
        .addr      (cur_addr)
    );

    // One pass computes the whole next state
    always_comb begin
        dev_nxt    = dev_r;
        exec       = 1'b0;
        ld_lo      = 1'b0;
        ld_hi      = 1'b0;
        pitch_mask = 8'hff << (3'd7 - horizontal_pitch);
        cur_show   = 1'b0;

        // Status byte refreshed each cycle, driven only on a read
        dev_nxt.oe_n = 1'b1;
        dev_nxt.dout = 8'h00;
        dev_nxt.dout[`LGAS_STAT_BUSY_BIT] = dev_r.busy;

        if (bus.bus_strobe) begin
            if (bus.register_select && bus.read_write) begin
                // Status read is answered even while busy
                dev_nxt.oe_n = 1'b0;
            end else if (bus.register_select) begin
                // Code write does not disturb busy
                dev_nxt.instr = bus.host_data_bus;
            end else if (!bus.read_write && !dev_r.busy) begin
                exec = 1'b1;
                case (dev_r.instr)
                    `LGAS_INS_CPL: begin
                        // Reserved top bit dropped
                        dev_nxt.cpl = bus.host_data_bus[`LGAS_CPL_MSB:0];
                    end

                    `LGAS_INS_NX: begin
                        dev_nxt.nx = bus.host_data_bus[`LGAS_NX_MSB:0];
                    end

                    `LGAS_INS_CLINE: begin
                        dev_nxt.cline = bus.host_data_bus[`LGAS_CLINE_MSB:0];
                    end

                    `LGAS_INS_DS_LO: begin
                        dev_nxt.ds_lo = bus.host_data_bus;
                    end

                    `LGAS_INS_DS_HI: begin
                        dev_nxt.ds_hi = bus.host_data_bus;
                    end

                    `LGAS_INS_CUR_LO: begin
                        ld_lo = 1'b1;
                    end

                    `LGAS_INS_CUR_HI: begin
                        ld_hi = 1'b1;
                    end

                    default: begin
                        // Codes outside this block are ignored and do not start execution
                        exec = 1'b0;
                    end
                endcase
            end
        end

        // Registered so the start output is a plain flop; a mode change shows one cycle later
        if (graphic_mode) begin
            dev_nxt.start = {dev_nxt.ds_hi, dev_nxt.ds_lo};
        end else begin
            // Upper nibble of the high byte is ignored in character mode
            dev_nxt.start = {4'h0, dev_nxt.ds_hi[`LGAS_CHAR_HI_MSB:0], dev_nxt.ds_lo};
        end

        // A refused parameter never reloads the execution count
        if (exec) begin
            dev_nxt.busy = 1'b1;
            dev_nxt.cnt  = 9'(`LGAS_EXEC_CYC - 1);
        end else if (dev_r.busy) begin
            if (dev_r.cnt == 9'h000) begin
                dev_nxt.busy = 1'b0;
            end else begin
                dev_nxt.cnt = dev_r.cnt - 9'h001;
            end
        end

        // Row scan wraps after the programmed count: duty is one over it
        if (line_tick) begin
            if (dev_r.scan >= dev_r.nx) begin
                dev_nxt.scan = 7'h00;
            end else begin
                dev_nxt.scan = dev_r.scan + 7'h01;
            end
        end

        // Cursor only in character mode, on its own cell and line
        if (!graphic_mode && cursor_enable && (dev_r.cline <= vertical_pitch)
            && (cell_addr[11:0] == cur_addr[11:0])
            && (cell_line == dev_r.cline)) begin
            cur_show = 1'b1;
        end
        // Cursor row is solid, so OR gives cursor priority over glyph dots
        dev_nxt.dots = cur_show ? (char_dots | pitch_mask) : char_dots;
    end

    // Synchronous reset puts every setting at its default
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dev_r.instr <= 8'h00;
            dev_r.busy  <= 1'b0;
            dev_r.cnt   <= 9'h000;

            dev_r.cpl   <= `LGAS_CPL_RST;
            dev_r.nx    <= `LGAS_NX_RST;
            dev_r.cline <= `LGAS_CLINE_RST;
            dev_r.ds_lo <= `LGAS_DS_RST;
            dev_r.ds_hi <= `LGAS_DS_RST;
            dev_r.start <= {`LGAS_DS_RST, `LGAS_DS_RST};

            dev_r.scan  <= 7'h00;
            dev_r.dots  <= 8'h00;

            dev_r.dout  <= 8'h00;
            dev_r.oe_n  <= 1'b1;
        end else begin
            dev_r <= dev_nxt;
        end
    end

    // Every output comes straight from a state flop
    assign bus.dev_do           = dev_r.dout;
    assign bus.dev_oe_n         = dev_r.oe_n;

    assign chars_per_line_count = dev_r.cpl;
    assign time_division_count  = dev_r.nx;
    assign cursor_line_value    = dev_r.cline;

    assign display_start_addr   = dev_r.start;
    assign ram_addr             = cur_addr;
    assign scan_line            = dev_r.scan;
    assign pixel_dots           = dev_r.dots;
    assign busy                 = dev_r.busy;
endmodule // lgas_device

`default_nettype wire

// ---- design/lgas_host.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "lgas_map.svh"

module lgas_host (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    lgas_bus_if.host              bus,
    input  wire logic [3:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output var  logic             s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output var  logic             s_axi_wready,
    output var  logic [1:0]       s_axi_bresp,
    output var  logic             s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [3:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output var  logic             s_axi_arready,
    output var  logic [31:0]      s_axi_rdata,
    output var  logic [1:0]       s_axi_rresp,
    output var  logic             s_axi_rvalid,
    input  wire logic             s_axi_rready
);
    import lgas_pkg::*;

    lgas_hst_s hst_r;
    lgas_hst_s hst_nxt;

    always_comb begin
        hst_nxt         = hst_r;
        hst_nxt.strobe  = 1'b0;
        hst_nxt.oe_n    = 1'b1;
        hst_nxt.awready = 1'b0;
        hst_nxt.wready  = 1'b0;
        hst_nxt.arready = 1'b0;

        // Write: take address and data in the same cycle, answer next
        if (s_axi_awvalid && s_axi_wvalid && !hst_r.awready && !hst_r.bvalid) begin
            hst_nxt.awready = 1'b1;
            hst_nxt.wready  = 1'b1;
            hst_nxt.bvalid  = 1'b1;
            hst_nxt.bresp   = 2'b10;
            if (s_axi_awaddr == `LGAS_HOST_CMD_OFS && s_axi_wstrb[1:0] == 2'b11
                && hst_r.st == HST_IDLE) begin
                hst_nxt.code   = s_axi_wdata[15:8];
                hst_nxt.param  = s_axi_wdata[7:0];
                hst_nxt.fix_hi = (s_axi_wdata[15:8] == `LGAS_INS_CUR_LO);
                if (s_axi_wdata[15:8] == `LGAS_INS_CUR_HI) begin
                    hst_nxt.hi_shadow = s_axi_wdata[7:0];
                end
                hst_nxt.st    = HST_POLL;
                hst_nxt.bresp = 2'b00;
            end
        end else if (hst_r.bvalid && s_axi_bready) begin
            hst_nxt.bvalid = 1'b0;
        end

        if (s_axi_arvalid && !hst_r.arready && !hst_r.rvalid) begin
            hst_nxt.arready = 1'b1;
            hst_nxt.rvalid  = 1'b1;
            hst_nxt.rresp   = 2'b00;
            hst_nxt.rdata   = 32'h0000_0000;
            if (s_axi_araddr == `LGAS_HOST_STAT_OFS) begin
                hst_nxt.rdata[`LGAS_BUSY_IDLE_BIT] = (hst_r.st != HST_IDLE);
                hst_nxt.rdata[7:0] = hst_r.last_stat;
            end else if (s_axi_araddr == `LGAS_HOST_CMD_OFS) begin
                hst_nxt.rdata[15:0] = {hst_r.code, hst_r.param};
            end else begin
                hst_nxt.rresp = 2'b10;
            end
        end else if (hst_r.rvalid && s_axi_rready) begin
            hst_nxt.rvalid = 1'b0;
        end

        case (hst_r.st)
            HST_IDLE: begin
            end
            HST_POLL: begin
                hst_nxt.strobe = 1'b1;
                hst_nxt.rs     = 1'b1;
                hst_nxt.rw     = 1'b1;
                hst_nxt.st     = HST_STAT;
            end
            HST_STAT: begin
                // Status stands only in the cycle after the strobe, so let the strobe cycle pass
                if (hst_r.strobe) begin
                    hst_nxt.st = HST_STAT;
                end else if (bus.host_data_bus[`LGAS_STAT_BUSY_BIT]) begin
                    hst_nxt.last_stat = bus.host_data_bus;
                    hst_nxt.st = HST_POLL;
                end else begin
                    hst_nxt.last_stat = bus.host_data_bus;
                    hst_nxt.strobe = 1'b1;
                    hst_nxt.rs     = 1'b1;
                    hst_nxt.rw     = 1'b0;
                    hst_nxt.dout   = hst_r.code;
                    hst_nxt.oe_n   = 1'b0;
                    hst_nxt.st     = HST_CODE;
                end
            end
            HST_CODE: begin
                // No busy check needed after the code write
                hst_nxt.strobe = 1'b1;
                hst_nxt.rs     = 1'b0;
                hst_nxt.rw     = 1'b0;
                hst_nxt.dout   = hst_r.param;
                hst_nxt.oe_n   = 1'b0;
                hst_nxt.st     = HST_PARAM;
            end
            HST_PARAM: begin
                // After a low cursor byte, always rewrite the high byte
                if (hst_r.fix_hi) begin
                    hst_nxt.fix_hi = 1'b0;
                    hst_nxt.code   = `LGAS_INS_CUR_HI;
                    hst_nxt.param  = hst_r.hi_shadow;
                    hst_nxt.st     = HST_POLL;
                end else begin
                    hst_nxt.st = HST_IDLE;
                end
            end
            default: begin
                hst_nxt.st = HST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            hst_r      <= '0;
            hst_r.st   <= HST_IDLE;
            hst_r.oe_n <= 1'b1;
        end else begin
            hst_r <= hst_nxt;
        end
    end

    assign bus.bus_strobe      = hst_r.strobe;
    assign bus.register_select = hst_r.rs;
    assign bus.read_write      = hst_r.rw;
    assign bus.host_do         = hst_r.dout;
    assign bus.host_oe_n       = hst_r.oe_n;
    assign s_axi_awready       = hst_r.awready;
    assign s_axi_wready        = hst_r.wready;
    assign s_axi_bresp         = hst_r.bresp;
    assign s_axi_bvalid        = hst_r.bvalid;
    assign s_axi_arready       = hst_r.arready;
    assign s_axi_rdata         = hst_r.rdata;
    assign s_axi_rresp         = hst_r.rresp;
    assign s_axi_rvalid        = hst_r.rvalid;
endmodule // lgas_host

`default_nettype wire

// ---- tb/lgas_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

module lgas_assertions (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       bus_strobe,
    input wire logic       register_select,
    input wire logic       read_write,
    input wire logic       host_oe_n,
    input wire logic [7:0] dev_do,
    input wire logic       dev_oe_n,
    input wire logic [7:0] host_data_bus
);
    logic [7:0] code_r;
    logic [9:0] age_r;
    logic       known;
    logic       stat_rd;
    logic       code_wr;
    logic       prm_wr;

    assign stat_rd = bus_strobe && register_select && read_write;
    assign code_wr = bus_strobe && register_select && !read_write;
    assign prm_wr  = bus_strobe && !register_select && !read_write;
    assign known   = code_r inside {8'h02, 8'h03, 8'h04, 8'h08, 8'h09, 8'h0a, 8'h0b};

    // Age saturates so a long idle bus never looks like a fresh command
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            code_r <= 8'h00;
            age_r  <= 10'h3ff;
        end else begin
            if (code_wr)
                code_r <= host_data_bus;
            if (prm_wr && known)
                age_r <= 10'h000;
            else if (age_r != 10'h3ff)
                age_r <= age_r + 10'h001;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_busy_seen;
        stat_rd ##1 dev_do[7];
    endsequence
    sequence s_low_cmd;
        code_wr && host_data_bus == 8'h0a ##1 prm_wr;
    endsequence
    sequence s_high_cmd;
        code_wr && host_data_bus == 8'h0b;
    endsequence

    a_stat_drive: assert property (stat_rd |=> !dev_oe_n)
        else $error("status byte not driven after status read");
    a_stat_only: assert property (!dev_oe_n |-> $past(stat_rd))
        else $error("status byte driven without status read");
    a_stat_zero: assert property (!dev_oe_n |-> dev_do[6:0] == 7'h00)
        else $error("status low bits not zero");
    a_code_param: assert property (code_wr |=> prm_wr)
        else $error("code write not followed by parameter write");
    a_poll_retry: assert property (s_busy_seen |-> ##2 stat_rd)
        else $error("bus used while device busy");
    a_busy_hold: assert property (!dev_oe_n && age_r >= 10'd3 && age_r <= 10'd495 |-> dev_do[7])
        else $error("busy missing during execution");
    a_busy_clear: assert property (!dev_oe_n && age_r >= 10'd510 && age_r != 10'h3ff |-> !dev_do[7])
        else $error("busy still set after execution time");
    a_write_drive: assert property (code_wr || prm_wr |-> !host_oe_n && !dev_oe_n == 1'b0)
        else $error("write cycle without host driving data");
    a_reset_idle: assert property ($rose(rst_n) |-> !bus_strobe && host_oe_n && dev_oe_n)
        else $error("bus not idle after reset");
    a_cursor_rewrite: assert property (s_low_cmd |-> ##[1:1000] s_high_cmd)
        else $error("high cursor byte not rewritten after low byte");
endmodule // lgas_assertions

`default_nettype wire

// ---- tb/lcd_geometry_address_setup_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module lcd_geometry_address_setup_test;
    import lgas_pkg::*;
    logic        sys_clk, rst_n;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        graphic_mode, cursor_enable, line_tick, ram_xfer_done, busy, saw_carry;
    logic [3:0]  vertical_pitch, cell_line, cursor_line_value;
    logic [2:0]  horizontal_pitch;
    logic [15:0] cell_addr, display_start_addr;
    lgas_addr_t  ram_addr;
    logic [7:0]  char_dots, pixel_dots;
    logic [6:0]  chars_per_line_count, time_division_count, scan_line;
    int          n_errors, n_checks;
    lgas_byte_t  tc [4];
    lgas_byte_t  tp [4];

    lgas_bus_if bus ();
    lgas_host u_lgas_host (.sys_clk, .rst_n, .bus(bus.host), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    lgas_device u_lgas_device (.sys_clk, .rst_n, .bus(bus.dev), .graphic_mode, .cursor_enable, .vertical_pitch,
        .horizontal_pitch, .line_tick, .cell_line, .cell_addr, .char_dots, .ram_xfer_done, .chars_per_line_count,
        .time_division_count, .cursor_line_value, .display_start_addr, .ram_addr, .scan_line, .pixel_dots, .busy);
    lgas_assertions u_lgas_assertions (.sys_clk, .rst_n, .bus_strobe(bus.bus_strobe),
        .register_select(bus.register_select), .read_write(bus.read_write), .host_oe_n(bus.host_oe_n),
        .dev_do(bus.dev_do), .dev_oe_n(bus.dev_oe_n), .host_data_bus(bus.host_data_bus));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // The carried value only lives until the host rewrites the high byte
    always @(posedge sys_clk) begin
        if (ram_addr === 16'h1305)
            saw_carry <= 1'b1;
    end

    task check(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    task end_sim();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge sys_clk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
        check("bresp", e, s_axi_bresp);
        s_axi_bready <= 1'b0;
    endtask

    task axi_rd(input logic [3:0] a, output logic [31:0] d, input logic [1:0] e);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
        d = s_axi_rdata;
        check("rresp", e, s_axi_rresp);
        s_axi_rready <= 1'b0;
    endtask

    task fin(input logic dec);
        int n;
        n = 0;
        if (dec) begin
            while (busy !== 1'b1) @(posedge sys_clk);
            while (busy === 1'b1) begin
                n++;
                @(posedge sys_clk);
            end
            check("busy_cycles", 32'h1f4, n);
        end
        do axi_rd(4'h4, rd, 2'b00); while (rd[31] !== 1'b0);
        while (dec && busy !== 1'b0) @(posedge sys_clk);
        #1;
    endtask

    task cmd(input lgas_byte_t c, input lgas_byte_t p, input logic dec);
        axi_wr(4'h0, {16'h0000, c, p}, 4'h3, 2'b00);
        fin(dec);
    endtask

    task tick(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            line_tick <= 1'b1;
            @(posedge sys_clk);
            line_tick <= 1'b0;
        end
        @(posedge sys_clk);
        #1;
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk);
        n_errors++;
        end_sim();
    end

    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 44'h0;
        {cursor_enable, line_tick, ram_xfer_done, saw_carry} = 4'h0;
        graphic_mode = 1'b1;
        {vertical_pitch, cell_line, horizontal_pitch, cell_addr, char_dots} = 35'h0;
        tc = '{8'h03, 8'h04, 8'h08, 8'h09};
        tp = '{8'h7f, 8'h0f, 8'h34, 8'ha5};
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        check("cpl_rst", 32'h01, chars_per_line_count);
        check("nx_rst", 32'h00, time_division_count);
        check("cline_rst", 32'h7, cursor_line_value);
        check("start_rst", 32'h0, display_start_addr);
        check("cur_rst", 32'h0, ram_addr);
        check("busy_rst", 32'h0, busy);
        axi_wr(4'h0, 32'h0000_027f, 4'h3, 2'b00);
        axi_wr(4'h0, 32'h0000_0401, 4'h3, 2'b10);
        fin(1'b1);
        check("cpl", 32'h7f, chars_per_line_count);
        foreach (tc[i])
            cmd(tc[i], tp[i], 1'b1);
        check("nx", 32'h7f, time_division_count);
        check("cline", 32'hf, cursor_line_value);
        check("start_gfx", 32'ha534, display_start_addr);
        graphic_mode <= 1'b0;
        @(posedge sys_clk);
        #1;
        check("start_chr", 32'h0534, display_start_addr);
        axi_rd(4'h0, rd, 2'b00);
        check("cmd_rd", 32'h09a5, rd[15:0]);
        axi_wr(4'h8, 32'h0, 4'hf, 2'b10);
        axi_wr(4'h0, 32'h0000_0233, 4'h1, 2'b10);
        axi_rd(4'h8, rd, 2'b10);
        check("bad_rd", 32'h0, rd);
        cmd(8'h05, 8'h33, 1'b0);
        check("undecoded_busy", 32'h0, busy);
        check("undecoded_cpl", 32'h7f, chars_per_line_count);
        cmd(8'h0b, 8'h12, 1'b1);
        check("cur_hi", 32'h1200, ram_addr);
        cmd(8'h0a, 8'h80, 1'b1);
        check("cur_lo", 32'h1280, ram_addr);
        cmd(8'h0a, 8'h05, 1'b1);
        check("cur_rewrite", 32'h1205, ram_addr);
        check("carry_seen", 32'h1, saw_carry);
        cmd(8'h0a, 8'hff, 1'b1);
        ram_xfer_done <= 1'b1;
        @(posedge sys_clk);
        ram_xfer_done <= 1'b0;
        @(posedge sys_clk);
        #1;
        check("cur_ripple", 32'h1300, ram_addr);
        cmd(8'h04, 8'h03, 1'b1);
        horizontal_pitch <= 3'h5;
        vertical_pitch <= 4'h7;
        cursor_enable <= 1'b1;
        cell_line <= 4'h3;
        cell_addr <= 16'hf300;
        char_dots <= 8'h11;
        repeat (3) @(posedge sys_clk);
        #1;
        check("cursor_on", 32'hfd, pixel_dots);
        vertical_pitch <= 4'h2;
        repeat (3) @(posedge sys_clk);
        #1;
        check("cursor_off", 32'h11, pixel_dots);
        cmd(8'h03, 8'h02, 1'b1);
        tick(2);
        check("scan_two", 32'h2, scan_line);
        tick(1);
        check("scan_wrap", 32'h0, scan_line);
        end_sim();
    end
endmodule // lcd_geometry_address_setup_test

`default_nettype wire
